// File: acspi_top.sv
// How it works
// - A high sleep control powers its channel down; its output data is zeroed.
// - Relock pin pulsed high at least 1 us restarts the timing loop, relock follows.
// - Lane select high sends each channel on lane one only, low uses both.
// - Test control high sends 101001100011 msb first instead of conversions.
// - In dual-lane mode, align low offsets lanes by half a word, high aligns them.
// - Serial enable high ignores direct pins except the relock pin and uses register settings.
// - Single lane uses one pair, dual lane two at half bit and clock rate; DDR.
// - Overrange output follows out-of-range data, refreshed once per frame.
// - Lock output is high while locked, low after losing lock.
// - A serial access is exactly 16 serial clocks within one select.
// - Input sampled on rising serial clock, output changed on falling.
// - Each select assertion starts a fresh 16-bit frame; host releases after 16th.
// - Select released before the 16th clock discards the access.
// - Select rising after a full frame latches address and performs the write.
// - Read/write bit is 1 for read, 0 for write; reserved bits are zero.
// - Address selects one of three registers; default address is 00h.
// - A write stores the data field at select release; reads ignore it.
// - Serial output floats unless selected; read data leaves on falling edges 8-15.
// - Mode 00 normal, 01 fixed pattern, 10 user pattern, 11 reserved.
// - Format bit set gives two's complement; stabilizer bit set enables it.
`timescale 1ns/1ps
module acspi_top (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire acspi_pkg::acspi_pins_type pins,
    input  wire logic [1:0][11:0]         sample,
    input  wire logic [1:0]               beyond_range,
    input  wire logic                     clock_jump,
    output logic                          sdo,
    output logic                          sdo_oe,
    output logic [1:0]                    lane_one_data,
    output logic [1:0]                    lane_zero_data,
    output logic                          lane_zero_oe,
    output logic                          serial_output_clock,
    output logic                          frame_marker,
    output logic                          chan_a_overrange,
    output logic                          chan_b_overrange,
    output logic                          dll_locked,
    output acspi_pkg::acspi_ctrl_type     active_ctrl
);
    import acspi_pkg::*;

    localparam acspi_pins_type PINS_IDLE = '{serial_select_n: 1'b1, default: 1'b0};

    acspi_pins_type s_pins;
    logic           sclk_d;
    logic           cs_d;
    logic           rise;
    logic           fall;
    logic           cs_rise;
    logic [4:0]     bit_cnt;
    logic [15:0]    shift_in;
    logic [7:0]     shift_out;
    logic [1:0]     addr_latched;
    acspi_ctrl_type ctrl_reg;
    logic [7:0]     pat_hi;
    logic [7:0]     pat_lo;
    acspi_ctrl_type pin_ctrl;
    acspi_dll_type  dll_state;
    acspi_dll_type  next_dll_state;
    logic [DLL_CNT_W-1:0] dll_cnt;
    logic           phase;
    logic           step;
    logic [3:0]     word_cnt;
    logic [3:0]     last_cnt;
    logic [3:0]     zero_load;
    logic [1:0][11:0] word_one;
    logic [1:0][11:0] captured;
    logic [1:0][5:0]  word_zero;
    logic [1:0][11:0] src;
    logic [11:0]    user_pattern;

    function automatic logic [7:0] reg_read(input logic [1:0] a,
                                            input logic [7:0] c,
                                            input logic [7:0] h,
                                            input logic [7:0] l);
        unique case (a)
            ADDR_CTRL:   reg_read = c;
            ADDR_PAT_HI: reg_read = h;
            ADDR_PAT_LO: reg_read = l;
            default:     reg_read = 8'h00;
        endcase
    endfunction

    // Core samples arrive offset binary; two's complement flips the sign bit.
    function automatic logic [11:0] out_word(input logic [11:0]    s,
                                             input acspi_ctrl_type c,
                                             input logic           sleep,
                                             input logic [11:0]    user);
        if (sleep) begin
            out_word = 12'h000;
        end else begin
            unique case (c.mode)
                MODE_FIXED: out_word = FIXED_PATTERN;
                MODE_USER:  out_word = user;
                default:    out_word = {s[11] ^ c.twos_comp, s[10:0]};
            endcase
        end
    endfunction

    acspi_sync #(.W($bits(acspi_pins_type)), .INIT(PINS_IDLE)) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in (pins),
        .sync_out (s_pins)
    );

    assign rise    = s_pins.sclk & ~sclk_d;
    assign fall    = ~s_pins.sclk & sclk_d;
    assign cs_rise = s_pins.serial_select_n & ~cs_d;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            cs_d   <= 1'b1;
        end else begin
            sclk_d <= s_pins.sclk;
            cs_d   <= s_pins.serial_select_n;
        end
    end

    // Counting saturates one past a frame so that extra clocks spoil the access.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt  <= 5'h00;
            shift_in <= 16'h0000;
        end else if (s_pins.serial_select_n) begin
            bit_cnt  <= 5'h00;
        end else if (rise) begin
            shift_in <= {shift_in[14:0], s_pins.sdi};
            if (bit_cnt != FRAME_OVER) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // Registers change only on a select release after exactly sixteen clocks.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg     <= acspi_ctrl_type'(CTRL_RESET);
            pat_hi       <= PAT_RESET;
            pat_lo       <= PAT_RESET;
            addr_latched <= ADDR_CTRL;
        end else if (cs_rise && bit_cnt == FRAME_BITS && s_pins.serial_enable) begin
            addr_latched <= shift_in[ADDR_MSB:ADDR_LSB];
            if (!shift_in[RW_BIT]) begin
                unique case (shift_in[ADDR_MSB:ADDR_LSB])
                    ADDR_CTRL:   ctrl_reg <= acspi_ctrl_type'(shift_in[DATA_MSB:0]);
                    ADDR_PAT_HI: pat_hi   <= shift_in[DATA_MSB:0];
                    ADDR_PAT_LO: pat_lo   <= shift_in[DATA_MSB:0];
                    default:     pat_lo   <= pat_lo;
                endcase
            end
        end
    end

    // The address is complete at the eighth rising edge; data leaves on later falls.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_out <= 8'h00;
            sdo       <= 1'b0;
            sdo_oe    <= 1'b0;
        end else begin
            sdo_oe <= s_pins.serial_enable & ~s_pins.serial_select_n;
            if (s_pins.serial_select_n) begin
                sdo <= 1'b0;
            end else if (rise && bit_cnt == ADDR_DONE) begin
                shift_out <= shift_in[EARLY_RW] ?
                             reg_read({shift_in[0], s_pins.sdi}, ctrl_reg, pat_hi, pat_lo) :
                             8'h00;
            end else if (fall && bit_cnt > ADDR_DONE && bit_cnt <= READ_LAST) begin
                sdo       <= shift_out[DATA_MSB];
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

    // The mode pin has no user pattern, so the pin path offers normal or fixed only.
    always_comb begin
        pin_ctrl.mode        = pins_test_mode(s_pins.test);
        pin_ctrl.single_lane = s_pins.lane_count_select;
        pin_ctrl.stabilizer  = s_pins.duty_stabilizer;
        pin_ctrl.twos_comp   = s_pins.output_format;
        pin_ctrl.align       = s_pins.word_align_select;
        pin_ctrl.sleep_a     = s_pins.chan_a_sleep;
        pin_ctrl.sleep_b     = s_pins.chan_b_sleep;
    end

    function automatic acspi_mode_type pins_test_mode(input logic t);
        pins_test_mode = t ? MODE_FIXED : MODE_NORMAL;
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            active_ctrl <= acspi_ctrl_type'(CTRL_RESET);
        end else begin
            active_ctrl <= s_pins.serial_enable ? ctrl_reg : pin_ctrl;
        end
    end

    always_comb begin
        next_dll_state = dll_state;
        unique case (dll_state)
            DLL_LOCKED: begin
                if (s_pins.dll_reset) begin
                    next_dll_state = DLL_HOLD;
                end else if (clock_jump) begin
                    next_dll_state = DLL_UNLOCKED;
                end
            end
            DLL_UNLOCKED: begin
                if (s_pins.dll_reset) begin
                    next_dll_state = DLL_HOLD;
                end
            end
            DLL_HOLD: begin
                if (!s_pins.dll_reset) begin
                    next_dll_state = (dll_cnt >= DLL_CNT_W'(DLL_PULSE_CYC - 1)) ?
                                     DLL_RELOCK : DLL_UNLOCKED;
                end
            end
            DLL_RELOCK: begin
                if (s_pins.dll_reset) begin
                    next_dll_state = DLL_HOLD;
                end else if (dll_cnt == DLL_CNT_W'(DLL_RELOCK_CYC - 1)) begin
                    next_dll_state = DLL_LOCKED;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dll_state  <= DLL_LOCKED;
            dll_cnt    <= '0;
            dll_locked <= 1'b1;
        end else begin
            dll_state  <= next_dll_state;
            dll_locked <= (next_dll_state == DLL_LOCKED);
            if (next_dll_state != dll_state) begin
                dll_cnt <= '0;
            end else if (dll_cnt != '1) begin
                dll_cnt <= dll_cnt + DLL_CNT_W'(1);
            end
        end
    end

    // Dual lane steps every other cycle, halving bit and clock rates.
    assign step         = active_ctrl.single_lane | phase;
    assign last_cnt     = active_ctrl.single_lane ? SINGLE_LAST : DUAL_LAST;
    assign zero_load    = active_ctrl.align ? 4'h0 : HALF_OFFSET;
    assign user_pattern = {pat_hi[5:0], pat_lo[7:2]};
    assign src[0]       = out_word(sample[0], active_ctrl, active_ctrl.sleep_a, user_pattern);
    assign src[1]       = out_word(sample[1], active_ctrl, active_ctrl.sleep_b, user_pattern);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase               <= 1'b0;
            word_cnt            <= 4'h0;
            serial_output_clock <= 1'b0;
            frame_marker        <= 1'b0;
            lane_zero_oe        <= 1'b0;
        end else begin
            phase        <= ~phase;
            lane_zero_oe <= ~active_ctrl.single_lane;
            if (step) begin
                serial_output_clock <= ~serial_output_clock;
                frame_marker        <= (word_cnt == 4'h0);
                word_cnt            <= (word_cnt >= last_cnt) ? 4'h0 : word_cnt + 4'h1;
            end
        end
    end

    // Each channel keeps its word in a shift register; lane zero trails when offset.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            word_one         <= '0;
            word_zero        <= '0;
            captured         <= '0;
            chan_a_overrange <= 1'b0;
            chan_b_overrange <= 1'b0;
        end else if (step) begin
            for (int ch = 0; ch < 2; ch++) begin
                if (word_cnt == 4'h0) begin
                    word_one[ch] <= src[ch];
                    captured[ch] <= src[ch];
                end else begin
                    word_one[ch] <= {word_one[ch][10:0], 1'b0};
                end
                if (active_ctrl.single_lane) begin
                    word_zero[ch] <= 6'h00;
                end else if (word_cnt == zero_load) begin
                    word_zero[ch] <= active_ctrl.align ? src[ch][5:0] : captured[ch][5:0];
                end else begin
                    word_zero[ch] <= {word_zero[ch][4:0], 1'b0};
                end
            end
            if (word_cnt == 4'h0) begin
                chan_a_overrange <= beyond_range[0] & ~active_ctrl.sleep_a;
                chan_b_overrange <= beyond_range[1] & ~active_ctrl.sleep_b;
            end
        end
    end

    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            lane_one_data[ch]  = word_one[ch][WORD_BITS-1];
            lane_zero_data[ch] = word_zero[ch][HALF_BITS-1];
        end
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_sleep_quiet;
        step && word_cnt == 4'h0 && active_ctrl.sleep_a |=> word_one[0] == 12'h000 && !chan_a_overrange;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("Sleeping channel sent data.");

    property p_dll_relock;
        dll_state == DLL_RELOCK && !s_pins.dll_reset && dll_cnt == DLL_CNT_W'(DLL_RELOCK_CYC - 1)
            |=> dll_locked;
    endproperty
    a_dll_relock: assert property (p_dll_relock) else $error("Loop did not relock in time.");

    property p_single_lane_quiet;
        active_ctrl.single_lane |=> !lane_zero_oe && lane_zero_data == 2'h0;
    endproperty
    a_single_lane_quiet: assert property (p_single_lane_quiet) else $error("Lane zero active.");

    property p_fixed_pattern;
        step && word_cnt == 4'h0 && active_ctrl.mode == MODE_FIXED && !active_ctrl.sleep_a
            |=> word_one[0] == FIXED_PATTERN;
    endproperty
    a_fixed_pattern: assert property (p_fixed_pattern) else $error("Fixed pattern wrong.");

    property p_pins_ignored;
        s_pins.serial_enable && $changed(pin_ctrl) |=> active_ctrl == $past(ctrl_reg);
    endproperty
    a_pins_ignored: assert property (p_pins_ignored) else $error("Pins took effect.");

    property p_dual_rate;
        step && !active_ctrl.single_lane ##1 !active_ctrl.single_lane |-> !step;
    endproperty
    a_dual_rate: assert property (p_dual_rate) else $error("Dual lane not at half rate.");

    property p_overrange_frame;
        !(step && word_cnt == 4'h0) |=> $stable(chan_a_overrange) && $stable(chan_b_overrange);
    endproperty
    a_overrange_frame: assert property (p_overrange_frame) else $error("Overrange mid-frame.");

    property p_lock_loss;
        dll_state == DLL_LOCKED && clock_jump && !s_pins.dll_reset |=> !dll_locked;
    endproperty
    a_lock_loss: assert property (p_lock_loss) else $error("Lock kept after jump.");

    property p_abort_no_write;
        cs_rise && bit_cnt != FRAME_BITS |=> $stable(ctrl_reg) && $stable(addr_latched);
    endproperty
    a_abort_no_write: assert property (p_abort_no_write) else $error("Short frame wrote.");

    property p_write_commit;
        cs_rise && bit_cnt == FRAME_BITS && s_pins.serial_enable && !shift_in[RW_BIT]
            && shift_in[ADDR_MSB:ADDR_LSB] == ADDR_CTRL |=> ctrl_reg == $past(shift_in[DATA_MSB:0]);
    endproperty
    a_write_commit: assert property (p_write_commit) else $error("Write not stored.");

    property p_sdo_float;
        s_pins.serial_select_n |=> !sdo_oe;
    endproperty
    a_sdo_float: assert property (p_sdo_float) else $error("Output driven unselected.");

    c_write: cover property (cs_rise && bit_cnt == FRAME_BITS && !shift_in[RW_BIT]);
    c_read: cover property (cs_rise && bit_cnt == FRAME_BITS && shift_in[RW_BIT]);
    c_relock: cover property (dll_state == DLL_RELOCK ##1 dll_state == DLL_LOCKED);
    c_abort: cover property (cs_rise && bit_cnt != FRAME_BITS && bit_cnt != 5'h00);
endmodule

// File: acspi_pkg.sv
package acspi_pkg;

    // Clock rate and the times that become cycle counts.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int DLL_PULSE_NS   = 1000;
    localparam int DLL_RELOCK_NS  = 5000;
    localparam int DLL_PULSE_CYC  = (DLL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLL_RELOCK_CYC = DLL_RELOCK_NS / CLK_PERIOD_NS;
    localparam int DLL_CNT_W      = 10;

    // Serial control frame layout.
    localparam logic [4:0] FRAME_BITS  = 5'h10;
    localparam logic [4:0] FRAME_OVER  = 5'h11;
    localparam logic [4:0] ADDR_DONE   = 5'h07;
    localparam logic [4:0] READ_LAST   = 5'h0F;
    localparam int         RW_BIT      = 15;
    localparam int         ADDR_MSB    = 9;
    localparam int         ADDR_LSB    = 8;
    localparam int         DATA_MSB    = 7;
    localparam int         EARLY_RW    = 6;

    // Register map and reset values.
    localparam logic [1:0] ADDR_CTRL   = 2'h0;
    localparam logic [1:0] ADDR_PAT_HI = 2'h1;
    localparam logic [1:0] ADDR_PAT_LO = 2'h2;
    localparam logic [7:0] CTRL_RESET  = 8'h08;
    localparam logic [7:0] PAT_RESET   = 8'h00;

    // Output word layout.
    localparam int          WORD_BITS     = 12;
    localparam int          HALF_BITS     = 6;
    localparam logic [3:0]  SINGLE_LAST   = 4'hB;
    localparam logic [3:0]  DUAL_LAST     = 4'h5;
    localparam logic [3:0]  HALF_OFFSET   = 4'h3;
    localparam logic [11:0] FIXED_PATTERN = 12'hA63;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_FIXED  = 2'b01,
        MODE_USER   = 2'b10,
        MODE_RSVD   = 2'b11
    } acspi_mode_type;

    typedef enum logic [1:0] {
        DLL_LOCKED   = 2'b00,
        DLL_HOLD     = 2'b01,
        DLL_RELOCK   = 2'b10,
        DLL_UNLOCKED = 2'b11
    } acspi_dll_type;

    // Same bit order as the device control register.
    typedef struct packed {
        acspi_mode_type mode;
        logic           single_lane;
        logic           stabilizer;
        logic           twos_comp;
        logic           align;
        logic           sleep_a;
        logic           sleep_b;
    } acspi_ctrl_type;

    // Direct pins and serial port wires as they arrive.
    typedef struct packed {
        logic chan_a_sleep;
        logic chan_b_sleep;
        logic dll_reset;
        logic lane_count_select;
        logic test;
        logic word_align_select;
        logic output_format;
        logic duty_stabilizer;
        logic serial_enable;
        logic serial_select_n;
        logic sclk;
        logic sdi;
    } acspi_pins_type;

endpackage

// File: acspi_sync.sv
`timescale 1ns/1ps
module acspi_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage;

    // The first stage feeds only the second one.
    // Reset loads each pin's idle level so that no false edge follows reset.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage    <= INIT;
            sync_out <= INIT;
        end else begin
            stage    <= async_in;
            sync_out <= stage;
        end
    end
endmodule

// File: acspi_host.sv
`timescale 1ns/1ps
module acspi_host (
    output logic      select_n,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo
);
    logic [7:0] rd_data;

    initial begin
        select_n = 1'b1;
        sclk     = 1'b0;
        sdi      = 1'b0;
        rd_data  = 8'h00;
    end

    // A count other than 16 is a deliberate fault used to provoke a discard.
    task automatic frame(input logic [15:0] word, input int n);
        int i;
        select_n = 1'b0;
        for (i = 0; i < n; i++) begin
            sdi = word[15 - (i % 16)];
            #62.5;
            sclk = 1'b1;
            if (i >= 8 && i < 16) rd_data = {rd_data[6:0], sdo};
            #62.5;
            sclk = 1'b0;
        end
        #62.5;
        select_n = 1'b1;
        sdi = ~sdi;
        #500;
    endtask
endmodule

// File: acspi_top_test.sv
`timescale 1ns/1ps
`define check_eq(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module acspi_top_test;
    import acspi_pkg::*;
    logic           mclk = 1'b0;
    logic           rst_n = 1'b0;
    logic           clock_jump = 1'b0;
    logic [1:0][11:0] sample = '0;
    logic [1:0]     beyond_range = 2'h0;
    acspi_pins_type drv = '0;
    acspi_pins_type pins;
    logic           sel_n, sclk, sdi, sdo, sdo_oe;
    logic [1:0]     lane_one_data, lane_zero_data;
    logic           lane_zero_oe, frame_marker, dll_locked, out_clk;
    logic           chan_a_overrange, chan_b_overrange;
    acspi_ctrl_type active_ctrl;
    int             bad_count = 0;
    int             compares = 0;

    always #5 mclk = ~mclk;

    always_comb begin
        pins                 = drv;
        pins.serial_select_n = sel_n;
        pins.sclk            = sclk;
        pins.sdi             = sdi;
    end

    acspi_top u_dut (.mclk(mclk), .rst_n(rst_n), .pins(pins), .sample(sample),
        .beyond_range(beyond_range), .clock_jump(clock_jump), .sdo(sdo), .sdo_oe(sdo_oe),
        .lane_one_data(lane_one_data), .lane_zero_data(lane_zero_data),
        .lane_zero_oe(lane_zero_oe), .serial_output_clock(out_clk), .frame_marker(frame_marker),
        .chan_a_overrange(chan_a_overrange), .chan_b_overrange(chan_b_overrange),
        .dll_locked(dll_locked), .active_ctrl(active_ctrl));

    acspi_host u_host (.select_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic xfer(input logic rd, input logic [1:0] a, input logic [7:0] d, input int n);
        u_host.frame({rd, 5'h00, a, d}, n);
        step(1);
    endtask

    task automatic end_of_test();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_reset();
        `check_eq(active_ctrl, 8'h08)
        `check_eq(dll_locked, 1'b1)
        `check_eq(sdo_oe, 1'b0)
        xfer(1'b1, 2'h0, 8'h00, 16);
        `check_eq(u_host.rd_data, 8'h08)
    endtask

    task automatic t_regs();
        xfer(1'b0, 2'h0, 8'h94, 16);
        `check_eq(active_ctrl, 8'h94)
        xfer(1'b0, 2'h1, 8'h3F, 16);
        xfer(1'b0, 2'h2, 8'hFC, 16);
        xfer(1'b1, 2'h1, 8'hFF, 16);
        `check_eq(u_host.rd_data, 8'h3F)
        xfer(1'b1, 2'h2, 8'h00, 16);
        `check_eq(u_host.rd_data, 8'hFC)
        xfer(1'b1, 2'h3, 8'h00, 16);
        `check_eq(u_host.rd_data, 8'h00)
        xfer(1'b1, 2'h0, 8'h00, 16);
        `check_eq(u_host.rd_data, 8'h94)
        `check_eq(sdo_oe, 1'b0)
    endtask

    task automatic t_short();
        xfer(1'b0, 2'h0, 8'h00, 15);
        `check_eq(active_ctrl, 8'h94)
        xfer(1'b0, 2'h0, 8'h00, 17);
        `check_eq(active_ctrl, 8'h94)
    endtask

    task automatic t_pins();
        drv.chan_a_sleep      = 1'b1;
        drv.lane_count_select = 1'b1;
        drv.test              = 1'b1;
        drv.word_align_select = 1'b0;
        step(6);
        `check_eq(active_ctrl, 8'h94)
        drv.serial_enable = 1'b0;
        step(6);
        `check_eq(active_ctrl, 8'h62)
        drv.output_format = 1'b1;
        step(6);
        `check_eq(active_ctrl, 8'h6A)
        drv.output_format = 1'b0;
    endtask

    task automatic t_pattern();
        logic [11:0] word;
        logic        oc;
        int i;
        step(30);
        `check_eq(lane_zero_oe, 1'b0)
        for (i = 0; i < 40 && frame_marker !== 1'b1; i++) step(1);
        for (i = 0; i < 12; i++) begin
            word = {word[10:0], lane_one_data[1]};
            step(1);
        end
        `check_eq(word, 12'hA63)
        oc = out_clk;
        step(1);
        `check_eq(out_clk, ~oc)
        beyond_range = 2'h3;
        step(30);
        `check_eq(chan_b_overrange, 1'b1)
        `check_eq(chan_a_overrange, 1'b0)
        beyond_range = 2'h0;
    endtask

    task automatic t_dual();
        logic [5:0] hi;
        logic [5:0] lo;
        logic       oc;
        int i;
        drv.serial_enable = 1'b1;
        step(4);
        xfer(1'b0, 2'h1, 8'h2D, 16);
        xfer(1'b0, 2'h2, 8'h30, 16);
        `check_eq(lane_zero_oe, 1'b1)
        for (i = 0; i < 40 && frame_marker !== 1'b0; i++) step(1);
        for (i = 0; i < 40 && frame_marker !== 1'b1; i++) step(1);
        for (i = 0; i < 6; i++) begin
            hi = {hi[4:0], lane_one_data[0]};
            lo = {lo[4:0], lane_zero_data[0]};
            oc = out_clk;
            step(1);
            `check_eq(out_clk, oc)
            step(1);
            `check_eq(out_clk, ~oc)
        end
        `check_eq({hi, lo}, 12'hB4C)
    endtask

    task automatic t_dll();
        int i;
        clock_jump = 1'b1;
        step(1);
        clock_jump = 1'b0;
        step(1);
        `check_eq(dll_locked, 1'b0)
        drv.dll_reset = 1'b1;
        step(110);
        drv.dll_reset = 1'b0;
        step(400);
        `check_eq(dll_locked, 1'b0)
        for (i = 0; i < 300 && dll_locked !== 1'b1; i++) step(1);
        `check_eq(dll_locked, 1'b1)
    endtask

    initial begin
        drv.serial_enable = 1'b1;
        step(2);
        rst_n = 1'b1;
        step(4);
        t_reset();
        t_regs();
        t_short();
        t_pins();
        t_pattern();
        t_dual();
        t_dll();
        end_of_test();
    end

    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end
endmodule
